// ### design/tmc_defines.svh
// constants for the eight bit timer/counter: offsets, fields, reset values, timing
//
// Summary of operation
// - count source select clear gives timer mode, one step per instruction cycle.
// - a write to the count register suppresses counting for two instruction cycles.
// - count source select set gives counter mode, stepping on external input edges.
// - counter mode steps on rising edge, or falling edge when edge select is set.
// - prescaler assign clear gives prescaler to timer, set gives it to watchdog.
// - one prescaler only; timer runs unscaled while it serves the watchdog.
// - timer prescale ratios run from 1:2 to 1:256 in powers of two.
// - prescaler counter has no address; software can neither read nor write it.
// - count register is eight bits, read/write, fed by eight bit prescaler.
// - count rolling from ff to 00 sets the overflow flag.
// - overflow request reaches the interrupt only while its enable bit is set.
// - counting stops during sleep, so overflow never wakes the processor.
// - external count input is synchronised before it steps the count register.
// - prescaler output or raw input is sampled on phases two and four.
// - with prescaler on timer, a count register write clears the prescaler.
// - prescaler assign and ratio field sit in config bits three down to zero.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register indices and apb byte addresses (byte address is four times index)
// ----------------------------------------------------------------------------
`define TMC_IDX_COUNT 8'h01
`define TMC_IDX_IRQ 8'h0b
`define TMC_IDX_CFG 8'h81
`define TMC_ADDR_COUNT 12'h004
`define TMC_ADDR_IRQ 12'h02c
`define TMC_ADDR_CFG 12'h204

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define TMC_CFG_RESET 8'hff
`define TMC_CFG_SRC_BIT 5
`define TMC_CFG_EDGE_BIT 4
`define TMC_CFG_ASSIGN_BIT 3
`define TMC_CFG_RATIO_HI 2
`define TMC_CFG_RATIO_LO 0
`define TMC_IRQ_EN_BIT 5
`define TMC_IRQ_FLAG_BIT 2
`define TMC_COUNT_MAX 8'hff
`define TMC_COUNT_ZERO 8'h00

// ----------------------------------------------------------------------------
// timing: instruction cycles during which a write blocks counting
// ----------------------------------------------------------------------------
`define TMC_INHIBIT_CYCLES 2'h2

`endif

// ### design/tmc_pkg.sv
// types shared by the timer/counter design files
package tmc_pkg;

  // four internal phases make one instruction cycle
  typedef enum logic [1:0] {
    TMC_Q1 = 2'b00,
    TMC_Q2 = 2'b01,
    TMC_Q3 = 2'b10,
    TMC_Q4 = 2'b11
  } tmc_phase_t;

endpackage

// ### design/tmc_sync.sv
// two flip-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
`default_nettype none

module tmc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// ### design/tmc_prescaler.sv
// shared prescaler counter with a selectable output tap
`timescale 1ns/1ps
`default_nettype none

module tmc_prescaler #(
  parameter int WIDTH = 8,
  parameter int SEL_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [SEL_W-1:0] ratio,
  output logic tap,
  output logic [WIDTH-1:0] count
);

  // no register address reaches this counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // tap 0 toggles on every tick, so ratio 0 divides by two
  assign tap = count[ratio];

endmodule

`default_nettype wire

// ### design/tmc_timer.sv
// eight bit timer/counter with shared prescaler, overflow interrupt and apb slave
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"

module tmc_timer #(
  parameter int ADDR_W = 12,
  parameter int PRE_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_COUNT_PIN,
  input wire logic SLEEP,
  input wire logic WDT_TICK,
  input wire logic WDT_CLEAR,
  output logic WDT_POST_TICK,
  output logic IRQ
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  tmc_pkg::tmc_phase_t phase;
  tmc_pkg::tmc_phase_t next_phase;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] cfg;
  logic irq_flag;
  logic irq_en;
  logic next_flag;
  logic [1:0] inhibit;
  logic src_prev;
  logic samp;
  logic tap_prev;
  logic pin_s;
  logic pre_tap;
  logic [PRE_W-1:0] pre_count;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire sel_count = PADDR == `TMC_ADDR_COUNT;
  wire sel_irq = PADDR == `TMC_ADDR_IRQ;
  wire sel_cfg = PADDR == `TMC_ADDR_CFG;
  wire mapped = sel_count | sel_irq | sel_cfg;
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire wr = access & PWRITE & PREADY;
  wire wr_count = wr & sel_count;
  wire wr_irq = wr & sel_irq;
  wire wr_cfg = wr & sel_cfg;

  // zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;

  // --------------------------------------------------------------------------
  // config fields
  // --------------------------------------------------------------------------
  wire cfg_src = cfg[`TMC_CFG_SRC_BIT];
  wire cfg_edge = cfg[`TMC_CFG_EDGE_BIT];
  wire assign_wdt = cfg[`TMC_CFG_ASSIGN_BIT];
  wire [2:0] ratio = cfg[`TMC_CFG_RATIO_HI:`TMC_CFG_RATIO_LO];

  // --------------------------------------------------------------------------
  // read mux, captured in the setup cycle
  // --------------------------------------------------------------------------
  wire [7:0] irq_view = ({7'h00, irq_en} << `TMC_IRQ_EN_BIT) |
                        ({7'h00, irq_flag} << `TMC_IRQ_FLAG_BIT);
  wire [7:0] rd_byte = sel_count ? count :
                       sel_irq ? irq_view :
                       sel_cfg ? cfg : 8'h00;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (setup & ~PWRITE) begin
      PRDATA <= {24'h000000, rd_byte};
    end
  end

  // --------------------------------------------------------------------------
  // instruction cycle phases
  // --------------------------------------------------------------------------
  always_comb begin
    case (phase)
      tmc_pkg::TMC_Q1: next_phase = tmc_pkg::TMC_Q2;
      tmc_pkg::TMC_Q2: next_phase = tmc_pkg::TMC_Q3;
      tmc_pkg::TMC_Q3: next_phase = tmc_pkg::TMC_Q4;
      tmc_pkg::TMC_Q4: next_phase = tmc_pkg::TMC_Q1;
      default: next_phase = tmc_pkg::TMC_Q1;
    endcase
  end

  wire at_q2 = phase == tmc_pkg::TMC_Q2;
  wire at_q4 = phase == tmc_pkg::TMC_Q4;

  // --------------------------------------------------------------------------
  // count source
  // --------------------------------------------------------------------------
  tmc_sync u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .d(EXT_COUNT_PIN),
    .q(pin_s)
  );

  // internal source is high in the second half of each instruction cycle
  wire int_level = (phase == tmc_pkg::TMC_Q3) | at_q4;
  wire ext_level = pin_s ^ cfg_edge;
  wire src_level = cfg_src ? ext_level : int_level;
  wire src_rise = src_level & ~src_prev;

  // --------------------------------------------------------------------------
  // shared prescaler
  // --------------------------------------------------------------------------
  // the timer side stops in sleep; the watchdog side keeps its own tick
  wire pre_tick = assign_wdt ? WDT_TICK : (src_rise & ~SLEEP);
  wire pre_clear = assign_wdt ? WDT_CLEAR : wr_count;

  tmc_prescaler #(
    .WIDTH(PRE_W),
    .SEL_W(3)
  ) u_prescaler (
    .clk(CLK),
    .rst(RST),
    .clear(pre_clear),
    .tick(pre_tick),
    .ratio(ratio),
    .tap(pre_tap),
    .count(pre_count)
  );

  // watchdog sees no scaling of the timer and vice versa
  wire pre_level = assign_wdt ? src_level : pre_tap;

  // --------------------------------------------------------------------------
  // phase sampling and increment
  // --------------------------------------------------------------------------
  wire samp_point = at_q2 | at_q4;
  wire samp_rise = samp_point & pre_level & ~samp;
  wire inc = samp_rise & (inhibit == 2'h0) & ~SLEEP;
  wire overflow = inc & (count == `TMC_COUNT_MAX) & ~wr_count;

  // a write overrides an increment in the same cycle
  assign next_count = wr_count ? PWDATA[7:0] :
                      inc ? count + 8'h01 : count;

  // an overflow in the clearing cycle survives the clear
  wire flag_clr = wr_irq & PWDATA[`TMC_IRQ_FLAG_BIT];
  assign next_flag = overflow | (irq_flag & ~flag_clr);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase <= tmc_pkg::TMC_Q1;
      src_prev <= 1'b0;
      // reset config counts falling edges, so an idle low pin reads as level one
      samp <= 1'b1;
      tap_prev <= 1'b0;
    end else begin
      phase <= next_phase;
      src_prev <= src_level;
      tap_prev <= pre_tap;
      if (samp_point) begin
        samp <= pre_level;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      count <= `TMC_COUNT_ZERO;
      irq_flag <= 1'b0;
    end else begin
      count <= next_count;
      irq_flag <= next_flag;
    end
  end

  // blocks the increments of the write cycle and the one after it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      inhibit <= 2'h0;
    end else if (wr_count) begin
      inhibit <= `TMC_INHIBIT_CYCLES;
    end else if (at_q4 && inhibit != 2'h0) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg <= `TMC_CFG_RESET;
      irq_en <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= PWDATA[7:0];
      end
      if (wr_irq) begin
        irq_en <= PWDATA[`TMC_IRQ_EN_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
      WDT_POST_TICK <= 1'b0;
    end else begin
      IRQ <= next_flag & irq_en;
      WDT_POST_TICK <= assign_wdt & pre_tap & ~tap_prev;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_timer_step;
    !cfg_src && assign_wdt && inhibit == 2'h0 && !SLEEP && at_q4 && !samp && !wr_count;
  endsequence

  sequence s_write_quiet;
    wr_count ##1 (!wr_count && !SLEEP) [*4];
  endsequence

  sequence s_ext_low;
    (cfg_src && assign_wdt && !SLEEP && !wr_count && src_level == 1'b0) [*6];
  endsequence

  chk_timer_mode_step:
    assert property (s_timer_step |=> count == $past(count) + 8'h01)
    else $error("timer mode did not step once in the instruction cycle");

  chk_write_inhibit_hold:
    assert property (s_write_quiet |-> count == $past(count, 3))
    else $error("count moved during the post-write inhibit");

  chk_counter_needs_edge:
    assert property (s_ext_low |-> count == $past(count, 5))
    else $error("counter mode stepped without an input edge");

  chk_edge_select_polarity:
    assert property (cfg_src && $rose(pin_s) && !$changed(cfg_edge) |-> src_level == !cfg_edge)
    else $error("counter edge polarity wrong");

  chk_ratio_min_spacing:
    assert property (inc && !assign_wdt && !cfg_src && ratio == 3'h0 && !$past(wr_count)
                     |=> (!inc || ratio != 3'h0 || assign_wdt || cfg_src) [*7])
    else $error("prescaled timer stepped faster than ratio 1:2");

  chk_write_clears_prescale:
    assert property (wr_count && !assign_wdt |=> pre_count == '0)
    else $error("count write left the prescaler uncleared");

  chk_overflow_sets_flag:
    assert property (overflow |=> irq_flag && count == `TMC_COUNT_ZERO)
    else $error("rollover did not set the overflow flag");

  chk_masked_irq_quiet:
    assert property (!irq_en && !$past(irq_en) |-> !IRQ)
    else $error("interrupt raised while overflow enable clear");

  chk_sleep_stops_count:
    assert property (SLEEP && !wr_count |=> $stable(count))
    else $error("count moved during sleep");

  chk_flag_set_wins:
    assert property (overflow && flag_clr |=> irq_flag)
    else $error("overflow lost to a same-cycle flag clear");

  chk_wdt_no_timer_scale:
    assert property (assign_wdt && at_q4 && !SLEEP && !samp && src_level && inhibit == 2'h0 && !wr_count
                     |=> count == $past(count) + 8'h01)
    else $error("timer scaled while prescaler serves the watchdog");

endmodule

`default_nettype wire

// ### test/tmc_pin_src.sv
// far-side model: external source that drives the count pin
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // each level stands four clocks, above the two that the synchroniser needs
  task automatic drive(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      drive(1'b1);
      drive(1'b0);
    end
  endtask
endmodule

`default_nettype wire

// ### test/tb_eight_bit_timer_counter.sv
// self-checking testbench for the eight bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"

module tb_eight_bit_timer_counter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic wdt_tick = 1'b0;
  logic [1:0] wdt_div = 2'h0;
  logic wdt_clear = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic irq;
  wire logic pin;
  wire logic wdt_post;
  logic [31:0] rdv;
  logic errv;
  int n_fail = 0;
  int check_count = 0;

  always #2 clk = ~clk;

  // watchdog ticks keep coming, so a prescaler shared by both would skew timer rates
  always @(posedge clk) begin
    wdt_div <= wdt_div + 2'h1;
    wdt_tick <= (wdt_div == 2'h3);
  end

  tmc_timer dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_COUNT_PIN(pin), .SLEEP(sleep), .WDT_TICK(wdt_tick),
    .WDT_CLEAR(wdt_clear), .WDT_POST_TICK(wdt_post), .IRQ(irq));

  tmc_pin_src src (.clk(clk), .pin(pin));

  // ----------------------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, `TMC_ADDR_CFG, 32'h0);
    chk(rdv, {24'h0, `TMC_CFG_RESET});
    apb(1'b0, `TMC_ADDR_IRQ, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdv, 32'h0);
    chk({31'h0, errv}, 32'h1);
  endtask

  // reads land two and seven clocks after the write edge, both inside the hold-off
  task automatic t_inhibit;
    apb(1'b1, `TMC_ADDR_CFG, 32'h08);
    apb(1'b1, `TMC_ADDR_COUNT, 32'hffffff40);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, 32'h40);
    repeat (2) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, 32'h40);
  endtask

  // per is clocks per step; the window holds exactly three steps
  task automatic t_rate(input logic [7:0] cfg, input int per);
    logic [7:0] c0;
    apb(1'b1, `TMC_ADDR_CFG, {24'h0, cfg});
    apb(1'b1, `TMC_ADDR_COUNT, 32'h0);
    repeat (16) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    c0 = rdv[7:0];
    repeat (per * 3 - 3) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, {24'h0, c0 + 8'h3});
  endtask

  task automatic t_overflow;
    logic [7:0] c0;
    apb(1'b1, `TMC_ADDR_CFG, 32'h08);
    apb(1'b1, `TMC_ADDR_IRQ, 32'h24);
    apb(1'b1, `TMC_ADDR_COUNT, 32'hfe);
    repeat (40) @(posedge clk);
    apb(1'b0, `TMC_ADDR_IRQ, 32'h0);
    chk(rdv, 32'h24);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    c0 = rdv[7:0];
    repeat (13) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, {24'h0, c0 + 8'h4});
    apb(1'b1, `TMC_ADDR_IRQ, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `TMC_ADDR_IRQ, 32'h0);
    chk(rdv, 32'h04);
    apb(1'b1, `TMC_ADDR_IRQ, 32'h04);
    apb(1'b1, `TMC_ADDR_IRQ, 32'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `TMC_ADDR_IRQ, 32'h0);
    chk(rdv, 32'h20);
  endtask

  // clears land every third edge from offset k; one offset meets the rollover edge
  task automatic t_flag_race;
    apb(1'b1, `TMC_ADDR_CFG, 32'h08);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `TMC_ADDR_COUNT, 32'hff);
      repeat (k) @(posedge clk);
      for (int j = 0; j < 6; j++) begin
        apb(1'b1, `TMC_ADDR_IRQ, 32'h04);
      end
      apb(1'b0, `TMC_ADDR_IRQ, 32'h0);
      chk(rdv, 32'h00);
    end
  endtask

  // post ticks over 64 clocks; watchdog ticks come every four clocks
  task automatic t_wdt(input logic [7:0] cfg, input logic clr, input int exp);
    int n;
    n = 0;
    apb(1'b1, `TMC_ADDR_CFG, {24'h0, cfg});
    wdt_clear <= clr;
    repeat (16) @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      if (wdt_post === 1'b1) begin
        n++;
      end
    end
    wdt_clear <= 1'b0;
    chk(n, exp);
  endtask

  task automatic t_sleep;
    logic [7:0] c0;
    sleep <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    c0 = rdv[7:0];
    repeat (61) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, {24'h0, c0});
    sleep <= 1'b0;
  endtask

  // config is changed only while the selected source level is low, so no edge is faked
  task automatic t_counter;
    logic [7:0] c0;
    apb(1'b1, `TMC_ADDR_CFG, 32'h28);
    repeat (12) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    c0 = rdv[7:0];
    src.pulses(5);
    src.drive(1'b1);
    repeat (12) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, {24'h0, c0 + 8'h6});
    apb(1'b1, `TMC_ADDR_CFG, 32'h38);
    repeat (12) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    c0 = rdv[7:0];
    src.pulses(3);
    repeat (12) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, {24'h0, c0 + 8'h3});
    apb(1'b1, `TMC_ADDR_CFG, 32'h20);
    apb(1'b1, `TMC_ADDR_COUNT, 32'h10);
    repeat (12) @(posedge clk);
    src.pulses(4);
    repeat (12) @(posedge clk);
    apb(1'b0, `TMC_ADDR_COUNT, 32'h0);
    chk(rdv, 32'h12);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_inhibit();
    for (int r = 0; r < 8; r++) begin
      t_rate({5'h0, r[2:0]}, 8 << r);
    end
    t_rate(8'hcf, 4);
    apb(1'b0, `TMC_ADDR_CFG, 32'h0);
    chk(rdv, 32'hcf);
    t_overflow();
    t_flag_race();
    t_sleep();
    t_wdt(8'h08, 1'b0, 8);
    t_wdt(8'h08, 1'b1, 0);
    t_wdt(8'h00, 1'b0, 0);
    t_counter();
    finish_test();
  end

  // the full run needs roughly seven thousand clocks
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule

`default_nettype wire
